// file: osc_ctrl_pkg.sv
// Constants, register layouts and types for the oscillator control block
package osc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_OSC_CTRL = 5'h00;
  localparam logic [4:0] OFF_CLK_DIV = 5'h04;
  localparam logic [4:0] OFF_RC_TRIM = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  // ----------------------------------------------------------------
  // Oscillator control field positions
  // ----------------------------------------------------------------
  localparam int ACT_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int PROT_BIT = 7;
  localparam int PLL_LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int DRV_BIT = 2;
  localparam int SEC_EN_BIT = 1;
  localparam int SWREQ_BIT = 0;

  // ----------------------------------------------------------------
  // Clock divider field positions and reset value
  // ----------------------------------------------------------------
  localparam int ROI_BIT = 15;
  localparam int RATIO_LSB = 12;
  localparam int SLOW_EN_BIT = 11;
  localparam int POST_LSB = 8;
  localparam logic [15:0] CLK_DIV_RST = 16'h3100;

  // Trim register width and reset value
  localparam int TRIM_W = 6;
  localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;

  // Switch settling time in cycles (hand-off to clock switcher)
  localparam logic [3:0] SWITCH_CYCLES = 4'h8;

  // Interrupt status bit positions
  localparam int EV_SWITCH = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_LOCK = 2;
  localparam int EV_W = 3;

  // ----------------------------------------------------------------
  // Clock source codes, shared by active and requested fields
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'h0,
    SRC_FAST_RC_POSTDIV_PLL = 3'h1,
    SRC_PRIMARY = 3'h2,
    SRC_PRIMARY_PLL = 3'h3,
    SRC_SECONDARY_OSC = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_LOW_POWER_FAST_RC_POSTDIV = 3'h6,
    SRC_FAST_RC_WITH_POSTDIV = 3'h7
  } source_t;

  // Classic Wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // Clock outputs towards the clock tree
  typedef struct packed {
    logic [2:0] activeSource;
    logic [7:0] cpuRatioLog;
    logic [7:0] postDivLog;
    logic secondaryEnable;
    logic secondaryDriveHigh;
    logic [TRIM_W-1:0] trim;
  } clk_cfg_t;

  // Which sources use the PLL
  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == SRC_PRIMARY_PLL) || (src == SRC_FAST_RC_POSTDIV_PLL);
  endfunction

endpackage

// file: osc_select_doze_divider.sv
// Oscillator select, slowdown ratio and fast RC postscaler control block
`timescale 1ns/1ps

module osc_select_doze_divider
  import osc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire wb_req_t wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Boot configuration and oscillator status
  input wire logic [2:0] boot_source_config,
  input wire logic secondary_source_kind,
  input wire logic pllLockedRaw,
  input wire logic clockFailRaw,
  input wire logic cpuIrq,
  // Clock configuration outputs
  output clk_cfg_t clkCfg,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] activeSrc_q; // Source in use
  logic [2:0] requestedSrc_q; // Source requested by software
  logic bootCaught_q; // Boot config taken after reset
  logic protect_q; // Switch lock
  logic pllLock_q; // PLL locked status
  logic fail_q; // Clock fail flag
  logic drive_q; // Secondary drive strength
  logic secEn_q; // Secondary oscillator enable
  logic swReq_q; // Switch in progress
  logic [3:0] swCnt_q; // Switch settling counter
  logic roi_q; // Recover on interrupt
  logic [2:0] ratio_q; // Slowdown ratio code
  logic slowEn_q; // Slowdown enable
  logic [2:0] post_q; // Fast RC postscaler code
  logic [TRIM_W-1:0] trim_q; // RC trim
  logic [EV_W-1:0] irqStat_q; // Sticky events
  logic [EV_W-1:0] irqMask_q; // Event mask
  logic [2:0] lockSync_q; // Lock synchroniser
  logic [2:0] failSync_q; // Fail synchroniser
  logic [2:0] roiIrqSync_q; // Interrupt line synchroniser

  // Bus decode
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic [15:0] wdat;
  logic switchDone;
  logic failEvent;
  logic lockRise;
  logic irqEvent;
  logic [15:0] oscRead;
  logic [15:0] divRead;

  // Access is taken on the first cycle, ack returns one cycle later
  assign access = wbReq.cyc && wbReq.stb && !wbAck;
  // Writes land at the edge that completes the cycle, with ack high,
  // so a master that drops the cycle early leaves the registers alone
  assign wrAccess = wbReq.cyc && wbReq.stb && wbReq.we && wbAck;
  // Reads capture data at the taking edge, so it stands with ack
  assign rdAccess = access && !wbReq.we;
  assign wdat = wbReq.dat[15:0];

  // Writes honour the low byte-enable lane pair only as whole register
  function automatic logic hit(input logic [4:0] off);
    hit = (wbReq.adr == off) && (wbReq.sel[1:0] == 2'h3);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers for asynchronous status inputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lockSync_q <= 3'h0;
      failSync_q <= 3'h0;
      roiIrqSync_q <= 3'h0;
    end
    else
    begin
      lockSync_q <= {lockSync_q[1:0], pllLockedRaw};
      failSync_q <= {failSync_q[1:0], clockFailRaw};
      roiIrqSync_q <= {roiIrqSync_q[1:0], cpuIrq};
    end
  end

  // Changes count once second and third stages agree
  // The first stage may be metastable, so only the later two are read
  assign failEvent = failSync_q[1] && failSync_q[2];
  // A lock rise is only an event while a PLL source runs and no switch ends
  assign lockRise = uses_pll(activeSrc_q) && !switchDone && lockSync_q[1] && lockSync_q[2]
    && !pllLock_q;
  assign irqEvent = roiIrqSync_q[1] && roiIrqSync_q[2];

  // ----------------------------------------------------------------
  // Bus acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wbAck <= 1'b0;
    else
      wbAck <= access;
  end

  // ----------------------------------------------------------------
  // Clock switch: requested source and switch sequence
  // ----------------------------------------------------------------
  // A switch runs for a fixed settling count; the request bit reads as one
  // until the new source is in use, which is how software polls for the end
  assign switchDone = swReq_q && (swCnt_q == SWITCH_CYCLES);

  // Boot configuration is taken once, on the first cycle out of reset

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bootCaught_q <= 1'b0;
      requestedSrc_q <= 3'h0;
    end
    else if (!bootCaught_q)
    begin
      bootCaught_q <= 1'b1;
      requestedSrc_q <= boot_source_config;
    end
    // Protect bit blocks source changes
    else if (wrAccess && hit(OFF_OSC_CTRL) && !protect_q)
      requestedSrc_q <= wdat[REQ_LSB +: 3];
  end

  // The switch counter only runs while a request is pending
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      activeSrc_q <= 3'h0;
      swReq_q <= 1'b0;
      swCnt_q <= 4'h0;
    end
    else if (switchDone)
    begin
      activeSrc_q <= requestedSrc_q;
      swReq_q <= 1'b0;
      swCnt_q <= 4'h0;
    end
    else if (swReq_q)
      swCnt_q <= swCnt_q + 4'h1;
    else if (wrAccess && hit(OFF_OSC_CTRL) && wdat[SWREQ_BIT] && !protect_q && bootCaught_q)
      swReq_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Lock protect, PLL lock and fail flag
  // ----------------------------------------------------------------
  // Once set, only a reset clears the lock; no write can release it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      protect_q <= 1'b0;
    else if (wrAccess && hit(OFF_OSC_CTRL) && wdat[PROT_BIT])
      protect_q <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pllLock_q <= 1'b0;
    else if (switchDone || !uses_pll(activeSrc_q))
      pllLock_q <= 1'b0;
    // Status follows the input once both late stages agree, else holds
    else if (lockSync_q[1] == lockSync_q[2])
      pllLock_q <= lockSync_q[2];
  end

  // A failure that lands with a clearing write keeps the flag set
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fail_q <= 1'b0;
    else if (failEvent)
      fail_q <= 1'b1;
    else if (wrAccess && hit(OFF_OSC_CTRL) && !wdat[FAIL_BIT])
      fail_q <= 1'b0;
  end

  // Secondary oscillator controls
  // Drive and enable are free of the lock; they do not move the source
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      drive_q <= 1'b0;
      secEn_q <= 1'b0;
    end
    else if (wrAccess && hit(OFF_OSC_CTRL))
    begin
      drive_q <= wdat[DRV_BIT];
      secEn_q <= wdat[SEC_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Clock divider register
  // ----------------------------------------------------------------
  // Ratio and postscaler codes take effect on the next clock
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      roi_q <= CLK_DIV_RST[ROI_BIT];
      ratio_q <= CLK_DIV_RST[RATIO_LSB +: 3];
      post_q <= CLK_DIV_RST[POST_LSB +: 3];
    end
    else if (wrAccess && hit(OFF_CLK_DIV))
    begin
      roi_q <= wdat[ROI_BIT];
      ratio_q <= wdat[RATIO_LSB +: 3];
      post_q <= wdat[POST_LSB +: 3];
    end
  end

  // Interrupt recovery overrides a write in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      slowEn_q <= CLK_DIV_RST[SLOW_EN_BIT];
    else if (roi_q && irqEvent)
      slowEn_q <= 1'b0;
    else if (wrAccess && hit(OFF_CLK_DIV))
      slowEn_q <= wdat[SLOW_EN_BIT];
  end

  // Trim code is handed on unchanged; the oscillator steps linearly
  // trim register storage
  always_ff @(posedge core_clk)
  begin
    if (rst)
      trim_q <= TRIM_RST;
    else if (wrAccess && hit(OFF_RC_TRIM))
      trim_q <= wdat[TRIM_W-1:0];
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // A switch end, a lock rise, or a failure while the fail flag is clear sets a sticky status bit; a read of the status register
  // clears it, and an event in the clearing cycle is not lost
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irqStat_q <= '0;
    else
    begin
      // Set wins over read clear
      irqStat_q <= ((rdAccess && wbReq.adr == OFF_IRQ_STAT) ? '0 : irqStat_q)
        | {lockRise, failEvent && !fail_q, switchDone};
    end
  end

  // Mask register, same layout as status
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irqMask_q <= '0;
    else if (wrAccess && hit(OFF_IRQ_MASK))
      irqMask_q <= wdat[EV_W-1:0];
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irqStat_q & irqMask_q);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Register images with unused positions held at zero
  always_comb
  begin
    oscRead = '0;
    oscRead[ACT_LSB +: 3] = activeSrc_q;
    oscRead[REQ_LSB +: 3] = requestedSrc_q;
    oscRead[PROT_BIT] = protect_q;
    oscRead[PLL_LOCK_BIT] = pllLock_q;
    oscRead[FAIL_BIT] = fail_q;
    oscRead[DRV_BIT] = drive_q;
    oscRead[SEC_EN_BIT] = secEn_q;
    oscRead[SWREQ_BIT] = swReq_q;
    divRead = '0;
    divRead[ROI_BIT] = roi_q;
    divRead[RATIO_LSB +: 3] = ratio_q;
    divRead[SLOW_EN_BIT] = slowEn_q;
    divRead[POST_LSB +: 3] = post_q;
  end

  // Read data is registered and holds its value until the next read is taken
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wbDatOut <= '0;
    else if (rdAccess)
    begin
      case (wbReq.adr)
        OFF_OSC_CTRL: wbDatOut <= {16'h0000, oscRead};
        OFF_CLK_DIV: wbDatOut <= {16'h0000, divRead};
        OFF_RC_TRIM: wbDatOut <= {26'h0, trim_q};
        OFF_IRQ_STAT: wbDatOut <= {29'h0, irqStat_q};
        OFF_IRQ_MASK: wbDatOut <= {29'h0, irqMask_q};
        // Unmapped reads return zero
        default: wbDatOut <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock configuration outputs
  // ----------------------------------------------------------------
  // Outputs are registered so the clock tree sees glitch-free settings
  // Code 7 of the postscaler means 256, which does not fit eight bits
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clkCfg <= '0;
    else
    begin
      clkCfg.activeSource <= activeSrc_q;
      // ratio 1:2^n, forced 1:1 when off
      clkCfg.cpuRatioLog <= slowEn_q ? (8'h01 << ratio_q) : 8'h01;
      // fast RC postscaler; low-power fast RC
      if (activeSrc_q == SRC_FAST_RC_WITH_POSTDIV
          || activeSrc_q == SRC_LOW_POWER_FAST_RC_POSTDIV)
        clkCfg.postDivLog <= (post_q == 3'h7) ? 8'hff : (8'h01 << post_q);
      else
        clkCfg.postDivLog <= 8'h01;
      clkCfg.secondaryEnable <= secEn_q;
      clkCfg.secondaryDriveHigh <= secondary_source_kind ? drive_q : 1'b0;
      clkCfg.trim <= trim_q;
    end
  end

endmodule // osc_select_doze_divider

// file: osc_select_doze_divider_properties.sv
// Bus and clock-configuration checker for the oscillator control block
`timescale 1ns/1ps
module osc_select_doze_divider_properties
  import osc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus
  input wire wb_req_t wbReq,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  // Status inputs
  input wire logic [2:0] boot_source_config,
  input wire logic secondary_source_kind,
  input wire logic pllLockedRaw,
  input wire logic clockFailRaw,
  input wire logic cpuIrq,
  // Outputs
  input wire clk_cfg_t clkCfg,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Last trim value written, for the follow check
  logic [TRIM_W-1:0] trimExp_q;
  sequence take;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  sequence readAck(logic [4:0] a);
    wbAck && wbReq.cyc && !wbReq.we && wbReq.adr == a;
  endsequence
  sequence trimWrite;
    wbAck && wbReq.we && wbReq.adr == OFF_RC_TRIM && wbReq.sel[1:0] == 2'h3;
  endsequence
  // Capture trim write data
  always_ff @(posedge core_clk)
  begin
    if (wbAck && wbReq.we && wbReq.adr == OFF_RC_TRIM && wbReq.sel[1:0] == 2'h3)
    begin
      trimExp_q <= wbReq.dat[TRIM_W-1:0];
    end
  end
  a_ack_follows_take: assert property (take |=> wbAck)
    else $error("no ack after request");
  a_ack_single_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wbAck |-> $past(wbReq.cyc && wbReq.stb))
    else $error("ack without request");
  a_osc_reserved_zero: assert property (readAck(OFF_OSC_CTRL) |->
    wbDatOut[15] == 1'b0 && wbDatOut[11] == 1'b0 && wbDatOut[6] == 1'b0 && wbDatOut[4] == 1'b0)
    else $error("reserved control bit set");
  a_div_low_zero: assert property (readAck(OFF_CLK_DIV) |->
    wbDatOut[7:0] == 8'h00 && wbDatOut[31:16] == 16'h0000)
    else $error("reserved divider bit set");
  a_unmapped_zero: assert property (wbAck && !wbReq.we && wbReq.adr[1:0] != 2'h0 |->
    wbDatOut == 32'h0) else $error("unmapped read not zero");
  a_ratio_power_two: assert property (!$past(rst) |-> $onehot(clkCfg.cpuRatioLog))
    else $error("ratio not a power of two");
  a_post_legal: assert property (!$past(rst) |->
    $onehot(clkCfg.postDivLog) || clkCfg.postDivLog == 8'hff) else $error("bad postscaler");
  a_trim_follows: assert property (trimWrite |=> ##[0:1] clkCfg.trim == trimExp_q)
    else $error("trim output not updated");
endmodule // osc_select_doze_divider_properties
bind osc_select_doze_divider osc_select_doze_divider_properties chk_i (.core_clk(core_clk),
  .rst(rst), .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck), .irq(irq), .clkCfg(clkCfg),
  .boot_source_config(boot_source_config), .secondary_source_kind(secondary_source_kind),
  .pllLockedRaw(pllLockedRaw), .clockFailRaw(clockFailRaw), .cpuIrq(cpuIrq));

// file: osc_select_doze_divider_test.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
module osc_select_doze_divider_test;
  import osc_ctrl_pkg::*;
  logic core_clk, rst, secondary_source_kind, pllLockedRaw, clockFailRaw, cpuIrq, irq, wbAck;
  logic [2:0] boot_source_config, act, req;
  logic [31:0] wbDatOut, r, d;
  wb_req_t wbReq;
  clk_cfg_t clkCfg;
  // Model state of the control register
  logic prot, fail, drv, sen, lck;
  int mismatches, checks, i, j;
  osc_select_doze_divider DUT (.core_clk(core_clk), .rst(rst), .wbReq(wbReq),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .boot_source_config(boot_source_config),
    .secondary_source_kind(secondary_source_kind), .pllLockedRaw(pllLockedRaw),
    .clockFailRaw(clockFailRaw), .cpuIrq(cpuIrq), .clkCfg(clkCfg), .irq(irq));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, read data left in r
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] dd);
    int k;
    k = 0;
    wbReq <= '{1'b1, 1'b1, w, a, 4'hf, dd};
    do begin @(posedge core_clk); k++; end while (wbAck !== 1'b1 && k < 50);
    r = wbDatOut;
    wbReq <= '0;
    @(posedge core_clk);
    if (k == 50) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  function automatic logic [31:0] oscv();
    return {16'h0, 1'b0, act, 1'b0, req, prot, 1'b0, lck, 1'b0, fail, drv, sen, 1'b0};
  endfunction
  // Control write with reserved and lock bits set and random active bits
  task automatic wosc(input logic go);
    d = {16'h0, 1'b1, 3'($urandom), 1'b1, req, prot, 3'b111, fail, drv, sen, go};
    wb(1'b1, OFF_OSC_CTRL, d);
  endtask
  task automatic sw(input logic [2:0] s);
    int n;
    n = 0;
    req = s;
    wosc(1'b1);
    do begin wb(1'b0, OFF_OSC_CTRL, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
    act = s;
    lck = pllLockedRaw && (s == 3'h1 || s == 3'h3);
    rd(OFF_OSC_CTRL, oscv());
    chk(clkCfg.activeSource, act);
  endtask
  task automatic hw(input logic [1:0] m);
    {clockFailRaw, cpuIrq} <= m;
    repeat (2) @(posedge core_clk);
    {clockFailRaw, cpuIrq} <= 2'b00;
    repeat (6) @(posedge core_clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    void'($urandom(92722));
    {rst, cpuIrq, clockFailRaw, pllLockedRaw, secondary_source_kind} <= 5'b10001;
    wbReq <= '0;
    req = 3'($urandom);
    boot_source_config <= req;
    {act, prot, fail, drv, sen, lck} = 8'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(OFF_OSC_CTRL, oscv());
    rd(OFF_CLK_DIV, 32'h3100);
    rd(5'h6, 32'h0);
    chk(clkCfg.cpuRatioLog, 32'h1);
    // Postscaler acts on both postscaled fast RC sources
    for (j = 0; j < 2; j++)
    begin
      sw(3'h7 - 3'(j));
      for (i = 0; i < 8; i++)
      begin
        d = {16'h0, 1'b0, i[2:0], 1'b1, i[2:0], 8'($urandom)};
        wb(1'b1, OFF_CLK_DIV, d);
        rd(OFF_CLK_DIV, d & 32'hff00);
        chk(clkCfg.cpuRatioLog, 32'h1 << i);
        chk(clkCfg.postDivLog, (i == 7) ? 32'hff : 32'h1 << i);
      end
    end
    wb(1'b1, OFF_CLK_DIV, 32'h5000);
    repeat (2) @(posedge core_clk);
    chk(clkCfg.cpuRatioLog, 32'h1);
    for (i = 0; i < 2; i++)
    begin
      d = {16'h0, i[0], 3'h4, 1'b1, 11'h0};
      wb(1'b1, OFF_CLK_DIV, d);
      hw(2'b01);
      rd(OFF_CLK_DIV, i ? d & 32'hf7ff : d);
      chk(clkCfg.cpuRatioLog, i ? 32'h1 : 32'h10);
    end
    d = $urandom;
    wb(1'b1, OFF_RC_TRIM, d);
    rd(OFF_RC_TRIM, d & 32'h3f);
    chk(clkCfg.trim, d[5:0]);
    d[2:0] = 3'($urandom);
    for (i = 0; i < 9; i++) sw((i == 8) ? 3'h2 : i[2:0] ^ d[2:0]);
    hw(2'b10);
    fail = 1'b1;
    rd(OFF_OSC_CTRL, oscv());
    rd(OFF_IRQ_STAT, 32'h3);
    rd(OFF_IRQ_STAT, 32'h0);
    fail = 1'b0;
    wosc(1'b0);
    rd(OFF_OSC_CTRL, oscv());
    pllLockedRaw <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(OFF_OSC_CTRL, oscv());
    chk(irq, 32'h0);
    sw(3'h3);
    wb(1'b1, OFF_IRQ_MASK, 32'h4);
    chk(irq, 32'h1);
    rd(OFF_IRQ_MASK, 32'h4);
    rd(OFF_IRQ_STAT, 32'h5);
    chk(irq, 32'h0);
    sw(3'h0);
    {sen, drv} = 2'b11;
    wosc(1'b0);
    secondary_source_kind <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(clkCfg.secondaryDriveHigh, 32'h0);
    secondary_source_kind <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({clkCfg.secondaryEnable, clkCfg.secondaryDriveHigh}, 32'h3);
    prot = 1'b1;
    wosc(1'b0);
    {req, prot} = {~req, 1'b0};
    wosc(1'b1);
    {req, prot} = {~req, 1'b1};
    repeat (12) @(posedge core_clk);
    rd(OFF_OSC_CTRL, oscv());
    stop_test();
  end
endmodule // osc_select_doze_divider_test
